// ---- shared/vss_map.svh ----
// constants of the vertical sequence select block: field positions, widths, codes
// assumes inclusion by vss_pkg and the core module only; definitions, no logic
// Summary of operation
// R1 - pointer codes 0-3 pick slot directly
// R2 - code 4/5 alternate slot pairs even/odd
// R3 - software never writes pointer codes 6, 7
// R4 - each slot selects one of four patterns
// R5 - per-pattern repeat count 0-7 per line
// R6 - four 8-bit region change line numbers
// R7 - regions advance 0 to 4 at change lines
// R8 - normal sequence stays within one line
// R9 - sweep runs pulse train across lines
// R10 - sweep ignores line sync until repeats done
// R11 - sweep only in regions 0 and 3
// R12 - sweep mode field decodes 00/01/10/11
// R13 - sweep repeat counts up to 2048
// R14 - second pulse enable bit gates overlay
// R15 - start position compared to pixel counter
// R16 - end position compared to same counter
// R17 - overlay only in sensor gate line
// R18 - AND case: internal wave starts high
// R19 - OR case: internal wave starts low
// R20 - combine bit per phase, 1 AND, 0 OR
`ifndef VSS_MAP_SVH
`define VSS_MAP_SVH

// ****************************************
// control word at address 0x0a
// ****************************************
`define VSS_CTRL_ADDR 8'h0a
`define VSS_CTRL_SWEEP_LSB 0
`define VSS_CTRL_SWEEP_MSB 1
`define VSS_CTRL_EN_BIT 2
`define VSS_CTRL_COMB_LSB 3
`define VSS_CTRL_COMB_MSB 6

// ****************************************
// widths and codes
// ****************************************
`define VSS_PTR_W 3
`define VSS_SLOT_W 2
`define VSS_REP_W 3
`define VSS_LINE_W 8
`define VSS_SWEEP_W 12
`define VSS_POS_W 13
`define VSS_PTR_PAIR01 3'h4
`define VSS_PTR_PAIR23 3'h5
`define VSS_LAST_REGION 3'h4
`define VSS_SWEEP_MAX 12'h800
`define VSS_LINE_RST 8'h00
`define VSS_REGION_RST 3'h0
`define VSS_PHASE_RST 4'h0

`endif

// ---- shared/vss_pkg.sv ----
// types of the vertical sequence select block
// assumes vss_map.svh sits in the include path
package vss_pkg;
`include "vss_map.svh"

  // one-hot sequencer states
  typedef enum logic [3:0] {
    VSS_IDLE = 4'b0001,
    VSS_RUN = 4'b0010,
    VSS_SWEEP = 4'b0100,
    VSS_DONE = 4'b1000
  } vss_state_t;

  // mode register contents other than the control word
  typedef struct packed {
    logic [4:0][`VSS_PTR_W-1:0] regionPtr;
    logic [3:0][`VSS_SLOT_W-1:0] patternSlot;
    logic [3:0][`VSS_REP_W-1:0] patternRepeat;
    logic [3:0][`VSS_LINE_W-1:0] changeLine;
    logic [`VSS_SWEEP_W-1:0] region0SweepRepeats;
    logic [`VSS_SWEEP_W-1:0] region3SweepRepeats;
    logic [3:0][`VSS_POS_W-1:0] pulseStart;
    logic [3:0][`VSS_POS_W-1:0] pulseEnd;
  } vss_cfg_t;

  // phase bits of the four transfer patterns, pattern index outer
  typedef logic [3:0][3:0] vss_wave_t;
endpackage

// ---- core/vss_vertical_select.sv ----
// vertical sequence select: region tracking, pattern choice, sweep, second pulse
// assumes the pattern generators, line sync and pixel counter run on sys_clk
module vss_vertical_select
  import vss_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic fieldStart,
  input wire logic lineSync,
  input wire logic sensorGateLine,
  input wire logic [`VSS_POS_W-1:0] stCount,
  input wire logic [7:0] ctrlWord,
  input wire vss_cfg_t cfg,
  input wire vss_wave_t patWave,
  input wire logic [3:0] patRepDone,
  output logic [3:0] vertPhase,
  output logic [2:0] activeRegion,
  output logic sweepActive,
  output logic patternActive
);

  // ****************************************
  // control word decode
  // ****************************************
  wire [1:0] sweepMode = ctrlWord[`VSS_CTRL_SWEEP_MSB:`VSS_CTRL_SWEEP_LSB]; // see R12
  wire secondEnable = ctrlWord[`VSS_CTRL_EN_BIT];
  wire [3:0] combineAnd = ctrlWord[`VSS_CTRL_COMB_MSB:`VSS_CTRL_COMB_LSB]; // see R20

  vss_state_t state_q, state_d;
  logic [`VSS_LINE_W-1:0] lineCnt_q, lineCnt_d;
  logic [2:0] region_q, region_d;
  logic [1:0] pat_q;
  logic [`VSS_SWEEP_W-1:0] repCnt_q, repCnt_d;
  logic [`VSS_SWEEP_W-1:0] target_q;
  logic [3:0] vertPhase_q;

  // ****************************************
  // line and region tracking
  // ****************************************
  wire sweeping = (state_q == VSS_SWEEP);
  wire [`VSS_LINE_W-1:0] nextLine = lineCnt_q + `VSS_LINE_W'(1);
  wire [`VSS_LINE_W-1:0] nextChange = cfg.changeLine[region_q[1:0]]; // see R6
  // region change waits while a sweep holds the line boundaries
  wire regionStep = lineSync && !sweeping && (region_q < `VSS_LAST_REGION)
    && (nextLine >= nextChange); // see R7

  always_comb begin
    lineCnt_d = lineCnt_q;
    region_d = region_q;
    if (fieldStart) begin
      lineCnt_d = `VSS_LINE_RST;
      region_d = `VSS_REGION_RST; // see R7
    end else if (lineSync) begin
      lineCnt_d = nextLine;
      if (regionStep) begin
        region_d = region_q + 3'h1;
      end
    end
  end

  // ****************************************
  // pointer, slot and pattern selection
  // ****************************************
  wire oddLine = lineCnt_d[0];
  wire [`VSS_PTR_W-1:0] ptrD = cfg.regionPtr[region_d];
  wire ptrDirect = (ptrD < `VSS_PTR_PAIR01); // see R1
  wire ptrPair01 = (ptrD == `VSS_PTR_PAIR01); // see R2
  wire ptrPair23 = (ptrD == `VSS_PTR_PAIR23); // see R2
  // codes 6 and 7 are unused; they simply run no pattern
  wire ptrValid = ptrDirect || ptrPair01 || ptrPair23; // see R3
  wire [1:0] slotIdx = ptrDirect ? ptrD[1:0] : {ptrPair23, oddLine};
  wire [1:0] patSel = cfg.patternSlot[slotIdx]; // see R4
  wire sweepRegion = ((region_d == 3'h0) && sweepMode[0])
    || ((region_d == 3'h3) && sweepMode[1]); // see R11
  wire [`VSS_SWEEP_W-1:0] sweepReps = (region_d == 3'h0) ? cfg.region0SweepRepeats
    : cfg.region3SweepRepeats;
  // counts above 2048 are clipped to the sweep maximum
  wire [`VSS_SWEEP_W-1:0] sweepTarget = (sweepReps > `VSS_SWEEP_MAX) ? `VSS_SWEEP_MAX
    : sweepReps; // see R13
  wire [`VSS_SWEEP_W-1:0] lineTarget = sweepRegion ? sweepTarget
    : {{(`VSS_SWEEP_W-`VSS_REP_W){1'b0}}, cfg.patternRepeat[patSel]}; // see R5

  // ****************************************
  // repeat sequencer
  // ****************************************
  wire lineStart = fieldStart || (lineSync && !sweeping); // see R10
  wire repDone = patRepDone[pat_q];
  wire [`VSS_SWEEP_W-1:0] repNext = repCnt_q + `VSS_SWEEP_W'(1);
  wire lastRep = repDone && (repNext >= target_q);

  // a new line always restarts the count; only a sweep outlives it
  // line sync inside a sweep is dropped here, so the pulse train is never cut short
  // a field start still aborts a sweep, which keeps a lost frame from hanging it
  always_comb begin
    state_d = state_q;
    repCnt_d = repCnt_q;
    if (lineStart) begin
      repCnt_d = '0; // see R8
      if (!ptrValid || (lineTarget == '0)) begin
        state_d = VSS_DONE;
      end else if (sweepRegion) begin
        state_d = VSS_SWEEP; // see R9
      end else begin
        state_d = VSS_RUN;
      end
    end else begin
      case (state_q)
        VSS_RUN, VSS_SWEEP: begin
          if (repDone) begin
            repCnt_d = repNext;
          end
          if (lastRep) begin
            state_d = VSS_DONE; // see R13
          end
        end
        VSS_IDLE, VSS_DONE: begin
          state_d = state_q;
        end
        default: begin
          state_d = VSS_IDLE;
        end
      endcase
    end
  end

  // sequencer and tracking registers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_q <= VSS_IDLE;
      lineCnt_q <= `VSS_LINE_RST;
      region_q <= `VSS_REGION_RST;
      repCnt_q <= '0;
      target_q <= '0;
      pat_q <= 2'h0;
    end else begin
      state_q <= state_d;
      lineCnt_q <= lineCnt_d;
      region_q <= region_d;
      repCnt_q <= repCnt_d;
      if (lineStart) begin
        target_q <= lineTarget;
        pat_q <= patSel;
      end
    end
  end

  // ****************************************
  // second pulse overlay
  // ****************************************
  wire running = (state_q == VSS_RUN) || sweeping;
  wire [3:0] baseWave = running ? patWave[pat_q] : `VSS_PHASE_RST;
  wire overlayOn = secondEnable && sensorGateLine; // see R14
  logic [3:0] inWindow;
  logic [3:0] spatWave;
  logic [3:0] mixedWave;

  // window opens at the start position and closes at the end position
  for (genvar i = 0; i < 4; i++) begin : g_phase
    assign inWindow[i] = (stCount >= cfg.pulseStart[i]) && (stCount < cfg.pulseEnd[i]); // see R15, R16
    assign spatWave[i] = combineAnd[i] ? !inWindow[i] : inWindow[i]; // see R18
    assign mixedWave[i] = combineAnd[i] ? (baseWave[i] && spatWave[i])
      : (baseWave[i] || spatWave[i]); // see R19
  end

  // only the sensor gate line sees the overlay
  wire [3:0] phaseD = overlayOn ? mixedWave : baseWave; // see R17

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      vertPhase_q <= `VSS_PHASE_RST;
    end else begin
      vertPhase_q <= phaseD; // see R16
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign vertPhase = vertPhase_q;
  assign activeRegion = region_q;
  assign sweepActive = sweeping;
  assign patternActive = running;

  // ****************************************
  // checks
  // ****************************************
  property p_field_resets_region;
    @(posedge sys_clk) disable iff (!rstn)
    fieldStart |=> (region_q == 3'h0) && (lineCnt_q == 8'h00);
  endproperty
  a_field_resets_region: assert property (p_field_resets_region) // see R7
    else $error("region not cleared by field start");

  property p_direct_pointer;
    @(posedge sys_clk) disable iff (!rstn)
    (lineStart && ptrDirect) |=> (pat_q == $past(cfg.patternSlot[ptrD[1:0]]));
  endproperty
  a_direct_pointer: assert property (p_direct_pointer) // see R1
    else $error("direct pointer picked wrong slot");

  property p_pair_pointer;
    @(posedge sys_clk) disable iff (!rstn)
    (lineStart && ptrPair01 && !oddLine) |=> (pat_q == $past(cfg.patternSlot[0]));
  endproperty
  a_pair_pointer: assert property (p_pair_pointer) // see R2
    else $error("even line of pair pointer used wrong slot");

  property p_run_bound;
    @(posedge sys_clk) disable iff (!rstn)
    (state_q == VSS_RUN) |-> (repCnt_q < target_q) && (target_q <= 12'h007);
  endproperty
  a_run_bound: assert property (p_run_bound) // see R5
    else $error("line repeat count out of range");

  property p_line_restart;
    @(posedge sys_clk) disable iff (!rstn)
    (state_q == VSS_RUN && lineSync) |=> (repCnt_q == '0) && (state_q != VSS_SWEEP || region_q != 3'h1);
  endproperty
  a_line_restart: assert property (p_line_restart) // see R8
    else $error("normal sequence survived line sync");

  property p_sweep_holds;
    @(posedge sys_clk) disable iff (!rstn)
    (sweeping && lineSync && !fieldStart && !repDone) |=> sweeping && $stable(region_q);
  endproperty
  a_sweep_holds: assert property (p_sweep_holds) // see R10
    else $error("sweep broken by line sync");

  property p_sweep_regions;
    @(posedge sys_clk) disable iff (!rstn)
    sweeping |-> (region_q == 3'h0 && sweepMode[0]) || (region_q == 3'h3 && sweepMode[1]);
  endproperty
  a_sweep_regions: assert property (p_sweep_regions) // see R11
    else $error("sweep outside regions 0 and 3");

  property p_sweep_end;
    @(posedge sys_clk) disable iff (!rstn)
    (sweeping && lastRep && !fieldStart) |=> (state_q == VSS_DONE) ##1 (target_q <= 12'h800);
  endproperty
  a_sweep_end: assert property (p_sweep_end) // see R13
    else $error("sweep did not stop at its count");

  property p_overlay_off;
    @(posedge sys_clk) disable iff (!rstn)
    (!secondEnable || !sensorGateLine) |=> (vertPhase_q == $past(baseWave));
  endproperty
  a_overlay_off: assert property (p_overlay_off) // see R17
    else $error("overlay applied while disabled or off gate line");

  property p_and_case;
    @(posedge sys_clk) disable iff (!rstn)
    (overlayOn && combineAnd[0] && inWindow[0]) |=> !vertPhase_q[0];
  endproperty
  a_and_case: assert property (p_and_case) // see R18
    else $error("and case did not pull phase one low");

  property p_or_case;
    @(posedge sys_clk) disable iff (!rstn)
    (overlayOn && !combineAnd[1] && inWindow[1]) |=> vertPhase_q[1];
  endproperty
  a_or_case: assert property (p_or_case) // see R19
    else $error("or case did not drive phase two high");

  // ****************************************
  // further checks on selection, regions, sweep and overlay
  // ****************************************
  // these cover the remaining pointer codes and the quiet cases of the overlay,
  // so a broken default path shows up even when the main scenarios pass
  property p_pair01_odd;
    @(posedge sys_clk) disable iff (!rstn)
    (lineStart && ptrPair01 && oddLine) |=> (pat_q == $past(cfg.patternSlot[1]));
  endproperty
  a_pair01_odd: assert property (p_pair01_odd) // see R2
    else $error("odd line of pair pointer used wrong slot");

  property p_pair23_even;
    @(posedge sys_clk) disable iff (!rstn)
    (lineStart && ptrPair23 && !oddLine) |=> (pat_q == $past(cfg.patternSlot[2]));
  endproperty
  a_pair23_even: assert property (p_pair23_even) // see R2
    else $error("even line of upper pair used wrong slot");

  property p_pair23_odd;
    @(posedge sys_clk) disable iff (!rstn)
    (lineStart && ptrPair23 && oddLine) |=> (pat_q == $past(cfg.patternSlot[3]));
  endproperty
  a_pair23_odd: assert property (p_pair23_odd) // see R2
    else $error("odd line of upper pair used wrong slot");

  property p_unused_code;
    @(posedge sys_clk) disable iff (!rstn)
    (lineStart && !ptrValid) |=> (state_q == VSS_DONE);
  endproperty
  a_unused_code: assert property (p_unused_code) // see R3
    else $error("unused pointer code started a pattern");

  property p_region_limit;
    @(posedge sys_clk) disable iff (!rstn)
    (region_q <= `VSS_LAST_REGION);
  endproperty
  a_region_limit: assert property (p_region_limit) // see R7
    else $error("region beyond the last one");

  property p_region_step;
    @(posedge sys_clk) disable iff (!rstn)
    (lineSync && !fieldStart && !sweeping && (region_q < `VSS_LAST_REGION) && (nextLine >= nextChange))
      |=> (region_q == $past(region_q) + 3'h1);
  endproperty
  a_region_step: assert property (p_region_step) // see R6
    else $error("region did not advance at change line");

  property p_normal_regions;
    @(posedge sys_clk) disable iff (!rstn)
    (lineStart && (region_d != 3'h0) && (region_d != 3'h3)) |=> !sweeping;
  endproperty
  a_normal_regions: assert property (p_normal_regions) // see R11
    else $error("sweep started in a normal region");

  property p_mode_none;
    @(posedge sys_clk) disable iff (!rstn)
    (lineStart && (sweepMode == 2'h0)) |=> !sweeping;
  endproperty
  a_mode_none: assert property (p_mode_none) // see R12
    else $error("sweep started with sweep mode off");

  property p_sweep_clip;
    @(posedge sys_clk) disable iff (!rstn)
    (lineStart && sweepRegion) |=> (target_q <= `VSS_SWEEP_MAX);
  endproperty
  a_sweep_clip: assert property (p_sweep_clip) // see R13
    else $error("sweep target above the maximum");

  property p_sweep_count;
    @(posedge sys_clk) disable iff (!rstn)
    sweeping |-> (repCnt_q < target_q);
  endproperty
  a_sweep_count: assert property (p_sweep_count) // see R9
    else $error("sweep ran past its repeat count");

  property p_idle_quiet;
    @(posedge sys_clk) disable iff (!rstn)
    (!running && !overlayOn) |=> (vertPhase_q == `VSS_PHASE_RST);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) // see R8
    else $error("phases active with no pattern running");

  property p_run_follows;
    @(posedge sys_clk) disable iff (!rstn)
    (running && !overlayOn) |=> (vertPhase_q == $past(patWave[pat_q]));
  endproperty
  a_run_follows: assert property (p_run_follows) // see R4
    else $error("phases do not follow the chosen pattern");

  property p_and_outside;
    @(posedge sys_clk) disable iff (!rstn)
    (overlayOn && combineAnd[0] && !inWindow[0]) |=> (vertPhase_q[0] == $past(baseWave[0]));
  endproperty
  a_and_outside: assert property (p_and_outside) // see R16
    else $error("and case changed phase one outside window");

  property p_or_outside;
    @(posedge sys_clk) disable iff (!rstn)
    (overlayOn && !combineAnd[1] && !inWindow[1]) |=> (vertPhase_q[1] == $past(baseWave[1]));
  endproperty
  a_or_outside: assert property (p_or_outside) // see R15
    else $error("or case changed phase two outside window");

  c_sweep_entered: cover property (@(posedge sys_clk) disable iff (!rstn) !sweeping ##1 sweeping);
  c_sweep_spans_line: cover property (@(posedge sys_clk) disable iff (!rstn) sweeping && lineSync);
  c_run_done: cover property (@(posedge sys_clk) disable iff (!rstn) state_q == VSS_RUN && lastRep);
  c_overlay: cover property (@(posedge sys_clk) disable iff (!rstn) overlayOn && running && |inWindow);
  c_last_region: cover property (@(posedge sys_clk) disable iff (!rstn) region_q == `VSS_LAST_REGION);

endmodule

// ---- test/vss_pattern_model.sv ----
// pattern generator and driver model facing the vertical select block
// assumes sys_clk and rstn are shared with the select block
module vss_pattern_model
  import vss_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  output vss_wave_t patWave,
  output logic [3:0] patRepDone
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // patterns
  // ****************************************
  logic [1:0] repCnt_q;
  // one-hot phase code per pattern, so the chosen pattern shows at the pins
  assign patWave = {4'h8, 4'h4, 4'h2, 4'h1};
  // shared end of repetition; free running keeps the model small
  assign patRepDone = {4{repCnt_q == 2'h3}};
  always_ff @(posedge sys_clk) begin
    if (!rstn) repCnt_q <= 2'h0;
    else repCnt_q <= repCnt_q + 2'h1;
  end
endmodule

// ---- test/tb_top.sv ----
// self-checking bench of the vertical sequence select block
// assumes the pattern model as far side; inputs change on falling edges
module tb_top;
  import vss_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // environment
  // ****************************************
  logic sys_clk = 0, rstn = 0, fieldStart = 0, lineSync = 0, sensorGateLine = 0;
  logic [12:0] stCount = 13'h0000;
  logic [7:0] ctrlWord = 8'h00;
  vss_cfg_t cfg = '0;
  vss_wave_t patWave;
  logic [3:0] patRepDone, vertPhase;
  logic [2:0] activeRegion;
  logic sweepActive, patternActive;
  int err_total = 0, checked = 0, cycles = 0, n;
  always #20 sys_clk = ~sys_clk;
  vss_pattern_model pm (.sys_clk(sys_clk), .rstn(rstn), .patWave(patWave), .patRepDone(patRepDone));
  vss_vertical_select uut (.sys_clk(sys_clk), .rstn(rstn), .fieldStart(fieldStart), .lineSync(lineSync),
    .sensorGateLine(sensorGateLine), .stCount(stCount), .ctrlWord(ctrlWord), .cfg(cfg), .patWave(patWave),
    .patRepDone(patRepDone), .vertPhase(vertPhase), .activeRegion(activeRegion),
    .sweepActive(sweepActive), .patternActive(patternActive));
  task automatic finish_test;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard: the whole run needs well under this
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  // one line start pulse, field start or line sync
  task automatic line(input logic fs);
    @(negedge sys_clk);
    fieldStart = fs;
    lineSync = !fs;
    @(negedge sys_clk);
    fieldStart = 0;
    lineSync = 0;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    chk(vertPhase, 4'h0);
    chk(activeRegion, 3'h0);
    chk({sweepActive, patternActive}, 2'h0);
  endtask
  // slot s holds pattern 3-s, so each code shows a distinct phase
  task automatic t_direct;
    for (int c = 0; c < 4; c++) begin
      cfg.regionPtr[0] = c[2:0];
      line(1);
      @(negedge sys_clk);
      chk(vertPhase, 4'h8 >> c);
    end
  endtask
  task automatic t_parity;
    for (int c = 0; c < 2; c++) begin
      cfg.regionPtr[0] = 3'h4 + c[2:0];
      line(1);
      @(negedge sys_clk);
      chk(vertPhase, 4'h8 >> (2 * c));
      line(0);
      @(negedge sys_clk);
      chk(vertPhase, 4'h4 >> (2 * c));
    end
  endtask
  // repetitions seen while the pattern runs, then phases idle
  task automatic t_repeat;
    cfg.regionPtr[0] = 3'h0;
    for (int k = 1; k < 8; k += 3) begin
      cfg.patternRepeat[3] = k[2:0];
      line(1);
      n = 0;
      repeat (40) begin
        if (patternActive && patRepDone[3]) n++;
        @(negedge sys_clk);
      end
      chk(n[11:0], k[11:0]);
      chk(vertPhase, 4'h0);
    end
    cfg.patternRepeat[3] = 3'h7;
  endtask
  task automatic t_regions;
    cfg.changeLine = {8'h08, 8'h06, 8'h04, 8'h02};
    line(1);
    for (int i = 1; i < 11; i++) begin
      line(0);
      chk(activeRegion, (i / 2 > 4) ? 4 : i / 2);
    end
  endtask
  // regions 0 and 3 sweep per mode bit, region 1 never
  task automatic t_sweep_modes;
    cfg.changeLine = {8'hc8, 8'h03, 8'h02, 8'h01};
    cfg.region0SweepRepeats = 12'h001;
    cfg.region3SweepRepeats = 12'h001;
    for (int m = 0; m < 4; m++) begin
      ctrlWord = m[7:0];
      line(1);
      chk(sweepActive, m[0]);
      repeat (10) @(negedge sys_clk);
      line(0);
      chk(sweepActive, 1'b0);
      line(0);
      line(0);
      chk(activeRegion, 3'h3);
      chk(sweepActive, m[1]);
      repeat (10) @(negedge sys_clk);
    end
  endtask
  // sweep spans a line sync; count clipped at the maximum
  task automatic t_sweep_count(input logic [11:0] reps, input logic [11:0] exp);
    ctrlWord = 8'h01;
    cfg.region0SweepRepeats = reps;
    line(1);
    n = 0;
    for (int i = 0; i < 9000; i++) begin
      if (sweepActive && patRepDone[0]) n++;
      lineSync = (i == 6);
      @(negedge sys_clk);
    end
    chk(n[11:0], exp);
    chk(activeRegion, 3'h0);
  endtask
  // start 100, end 200; phase one AND, others OR unless noted
  task automatic t_overlay;
    logic [12:0] stv [8] = '{13'h0096, 13'h0032, 13'h0064, 13'h00c8, 13'h0096, 13'h0096, 13'h0096, 13'h0096};
    logic gate [8] = '{1, 1, 1, 1, 0, 1, 1, 1};
    logic [7:0] cw [8] = '{8'h0c, 8'h0c, 8'h0c, 8'h0c, 8'h0c, 8'h08, 8'h04, 8'h7c};
    logic [3:0] ev [8] = '{4'he, 4'h1, 4'he, 4'h1, 4'h1, 4'h1, 4'hf, 4'h0};
    ctrlWord = 8'h0c;
    cfg.regionPtr[0] = 3'h3;
    cfg.changeLine = {4{8'hc8}};
    line(1);
    for (int i = 0; i < 8; i++) begin
      stCount = stv[i];
      sensorGateLine = gate[i];
      ctrlWord = cw[i];
      @(negedge sys_clk);
      chk(vertPhase, ev[i]);
      @(negedge sys_clk);
    end
  endtask
  initial begin
    cfg.patternSlot = {2'h0, 2'h1, 2'h2, 2'h3};
    cfg.patternRepeat = {4{3'h7}};
    cfg.changeLine = {4{8'hc8}};
    cfg.pulseStart = {4{13'h0064}};
    cfg.pulseEnd = {4{13'h00c8}};
    cfg.regionPtr = {3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
    repeat (12) @(negedge sys_clk);
    t_reset();
    rstn = 1;
    t_direct();
    t_parity();
    t_repeat();
    t_regions();
    t_sweep_modes();
    t_sweep_count(12'h00a, 12'h00a);
    t_sweep_count(12'h900, 12'h800);
    t_overlay();
    finish_test();
  end
endmodule
